// ### rtl/sac_ctrl.sv
// Conversion timing, serial result port and APB registers
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
    parameter int RES_W = sac_pkg::RES_W
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sac_pkg::sac_pin_in_s pins_in,
    output sac_pkg::sac_pin_out_s pins_out,
    input wire logic [RES_W-1:0] core_result,
    output logic core_hold
);

    localparam int CNT_W = sac_pkg::CNT_W;
    localparam int PH_W = sac_pkg::PH_W;
    localparam int BIT_W = $clog2(RES_W + 1);
    localparam int FIN_A = sac_pkg::FIN_CYC;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    sac_pkg::sac_pin_in_s pin_s;

    sac_sync #(
        .WIDTH(4),
        .RST_VAL(sac_pkg::PIN_IN_RST)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(pins_in),
        .sync_out(pin_s)
    );

    // ************************************************************
    // State
    // ************************************************************
    sac_pkg::sac_state_e state_reg, state_next;
    logic [CNT_W-1:0] conversion_start_n_cnt_reg, conversion_start_n_cnt_next;
    logic [PH_W-1:0] ph_reg, ph_next;
    logic [BIT_W-1:0] bits_reg, bits_next;
    logic [RES_W-1:0] sh_reg, sh_next;
    logic [RES_W-1:0] result_reg, result_next;
    logic data_reg, data_next;
    logic sclk_reg, sclk_next;
    logic ext_reg, ext_next;
    logic skip_reg, skip_next;
    logic lost_reg, lost_next;
    logic conversion_start_n_prev_reg, sclk_prev_reg;
    logic soft_start_reg, soft_start_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;

    logic busy_reg;
    logic conversion_start_n_fall;
    logic sclk_rise;
    logic start_fire;
    logic load_pulse;
    logic apb_wr;

    assign busy_reg = (state_reg != sac_pkg::SAC_IDLE);
    assign conversion_start_n_fall = conversion_start_n_prev_reg && !pin_s.conversion_start_n;
    assign sclk_rise = !sclk_prev_reg && pin_s.serial_bit_clock;
    // Output enable plays no part here [R2]
    assign start_fire = !busy_reg && (conversion_start_n_fall || soft_start_reg); // [R1]
    assign load_pulse = (state_reg == sac_pkg::SAC_TAIL) && (conversion_start_n_cnt_reg == sac_pkg::DONE_M1);
    assign apb_wr = psel && penable && pwrite;

    // ************************************************************
    // Sequencer next state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        conversion_start_n_cnt_next = conversion_start_n_cnt_reg;
        ph_next = ph_reg;
        bits_next = bits_reg;
        sh_next = sh_reg;
        result_next = result_reg;
        data_next = data_reg;
        sclk_next = sclk_reg;
        ext_next = ext_reg;
        skip_next = skip_reg;
        lost_next = lost_reg;
        // Mode follows the pin only while idle so a frame never changes source [R24]
        if (!busy_reg)
        begin
            ext_next = pin_s.clock_source_select;
        end
        // Host clock drives the shift register, gated by output enable [R15] [R27]
        if (ext_reg && sclk_rise && !pin_s.cs_n)
        begin
            data_next = sh_reg[RES_W-1]; // [R10]
            sh_next = {sh_reg[RES_W-2:0], 1'b0};
        end
        case (state_reg)
            sac_pkg::SAC_IDLE:
            begin
                if (start_fire) // [R1] [R5]
                begin
                    state_next = sac_pkg::SAC_LEAD;
                    conversion_start_n_cnt_next = '0;
                    skip_next = 1'b0;
                end
            end
            sac_pkg::SAC_LEAD:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                if (conversion_start_n_cnt_reg == sac_pkg::TX_START_M1)
                begin
                    ph_next = '0;
                    bits_next = BIT_W'(RES_W);
                    // Previous result goes out during this conversion [R9]
                    state_next = ext_reg ? sac_pkg::SAC_TAIL : sac_pkg::SAC_SLOW;
                end
            end
            sac_pkg::SAC_SLOW:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                ph_next = ph_reg + PH_W'(1);
                // Bit changes mid low phase so it is steady at both edges [R11]
                if (ph_reg == sac_pkg::SETUP_PH)
                begin
                    data_next = sh_reg[RES_W-1]; // [R10]
                    sh_next = {sh_reg[RES_W-2:0], 1'b0};
                    bits_next = bits_reg - BIT_W'(1);
                end
                if (ph_reg == sac_pkg::HALF_M1) // [R13]
                begin
                    ph_next = '0;
                    sclk_next = 1'b1;
                    state_next = sac_pkg::SAC_SHIGH;
                end
            end
            sac_pkg::SAC_SHIGH:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                ph_next = ph_reg + PH_W'(1);
                if (ph_reg == sac_pkg::HALF_M1) // [R13]
                begin
                    ph_next = '0;
                    sclk_next = 1'b0;
                    state_next = (bits_reg == '0) ? sac_pkg::SAC_SEND : sac_pkg::SAC_SLOW;
                end
            end
            sac_pkg::SAC_SEND:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                ph_next = ph_reg + PH_W'(1);
                if (ph_reg == sac_pkg::SETUP_PH)
                begin
                    data_next = 1'b0; // [R26]
                    state_next = sac_pkg::SAC_TAIL;
                end
            end
            sac_pkg::SAC_TAIL:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                // A high host clock near the end blocks the update [R17]
                if (ext_reg && !pin_s.cs_n && pin_s.serial_bit_clock && conversion_start_n_cnt_reg >= sac_pkg::GUARD_START)
                begin
                    skip_next = 1'b1;
                end
                if (load_pulse) // [R8] [R28]
                begin
                    result_next = core_result;
                    ph_next = '0;
                    state_next = sac_pkg::SAC_FIN;
                    if (!ext_reg || !skip_reg)
                    begin
                        sh_next = core_result;
                    end
                    else
                    begin
                        lost_next = 1'b1;
                    end
                end
            end
            sac_pkg::SAC_FIN:
            begin
                conversion_start_n_cnt_next = conversion_start_n_cnt_reg + CNT_W'(1);
                ph_next = ph_reg + PH_W'(1);
                if (ph_reg == sac_pkg::FIN_M1) // [R4] [R7] [R14]
                begin
                    state_next = sac_pkg::SAC_IDLE;
                end
            end
            default:
            begin
                state_next = sac_pkg::SAC_IDLE;
            end
        endcase
        // Hardware set beats a software clear in the same cycle
        if (apb_wr && paddr == sac_pkg::OFF_STATUS && pwdata[sac_pkg::ST_LOST_BIT] &&
            !(load_pulse && ext_reg && skip_reg))
        begin
            lost_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= sac_pkg::SAC_IDLE;
            conversion_start_n_cnt_reg <= '0;
            ph_reg <= '0;
            bits_reg <= '0;
            sh_reg <= '0;
            result_reg <= '0;
            data_reg <= 1'b0;
            sclk_reg <= 1'b0;
            ext_reg <= 1'b0;
            skip_reg <= 1'b0;
            lost_reg <= 1'b0;
            conversion_start_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            conversion_start_n_cnt_reg <= conversion_start_n_cnt_next;
            ph_reg <= ph_next;
            bits_reg <= bits_next;
            sh_reg <= sh_next;
            result_reg <= result_next;
            data_reg <= data_next;
            sclk_reg <= sclk_next;
            ext_reg <= ext_next;
            skip_reg <= skip_next;
            lost_reg <= lost_next;
            conversion_start_n_prev_reg <= pin_s.conversion_start_n;
            sclk_prev_reg <= pin_s.serial_bit_clock;
        end
    end

    // ************************************************************
    // APB slave, no wait state; read data leave a flop loaded in the setup phase
    // ************************************************************
    always_comb
    begin
        prdata_next = prdata_reg;
        err_next = err_reg;
        soft_start_next = 1'b0;
        if (psel && !penable)
        begin
            prdata_next = '0;
            err_next = 1'b0;
            case (paddr)
                sac_pkg::OFF_CTRL:
                begin
                    prdata_next = '0;
                end
                sac_pkg::OFF_STATUS:
                begin
                    prdata_next[sac_pkg::ST_BUSY_BIT] = busy_reg;
                    prdata_next[sac_pkg::ST_LOST_BIT] = lost_reg;
                    prdata_next[sac_pkg::ST_EXT_BIT] = ext_reg;
                    prdata_next[sac_pkg::ST_SKIP_BIT] = skip_reg;
                end
                sac_pkg::OFF_RESULT:
                begin
                    prdata_next[RES_W-1:0] = result_reg; // [R23]
                end
                default:
                begin
                    err_next = 1'b1;
                end
            endcase
        end
        if (apb_wr && paddr == sac_pkg::OFF_CTRL)
        begin
            soft_start_next = pwdata[sac_pkg::CTRL_START_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_reg <= '0;
            err_reg <= 1'b0;
            soft_start_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            err_reg <= err_next;
            soft_start_reg <= soft_start_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = psel && penable;
    assign pslverr = psel && penable && err_reg;

    // ************************************************************
    // Pins
    // ************************************************************
    // Busy falls in the detect cycle to keep start-to-busy short [R5] [R6] [R12]
    assign pins_out.busy_n_o = !(busy_reg || start_fire);
    assign pins_out.busy_n_oe = !pin_s.cs_n; // [R25]
    assign pins_out.data_o = data_reg;
    assign pins_out.data_oe = !pin_s.cs_n; // [R25]
    assign pins_out.serial_bit_clock_o = sclk_reg;
    assign pins_out.serial_bit_clock_oe = !pin_s.cs_n && !ext_reg; // [R24] [R25]
    assign core_hold = busy_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [CNT_W:0] busy_len_reg;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_len_reg <= '0;
        end
        else
        begin
            busy_len_reg <= busy_reg ? busy_len_reg + (CNT_W+1)'(1) : '0;
        end
    end

    start_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R5]
        start_fire |-> !pins_out.busy_n_o ##1 busy_reg)
        else $error("busy not low at start");

    start_ignored_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
        (busy_reg && conversion_start_n_fall && state_reg != sac_pkg::SAC_FIN) |=> conversion_start_n_cnt_reg != '0)
        else $error("start accepted during conversion");

    cs_free_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
        (start_fire && pin_s.cs_n) |=> busy_reg)
        else $error("start blocked by output enable");

    busy_max_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6] [R4]
        busy_len_reg <= (CNT_W+1)'(sac_pkg::BUSY_MAX_CYC))
        else $error("busy low too long");

    load_to_rise_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8] [R7]
        load_pulse |=> busy_reg ##FIN_A !busy_reg)
        else $error("busy rise not after load delay");

    idle_low_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R26]
        (!ext_reg && (state_reg == sac_pkg::SAC_IDLE || state_reg == sac_pkg::SAC_TAIL))
        |-> (!sclk_reg && !data_reg))
        else $error("internal clock or data not low when idle");

    bit_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        (!ext_reg && ($rose(sclk_reg) || $fell(sclk_reg))) |-> $stable(data_reg))
        else $error("data moved on a clock edge");

    frame_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        sclk_reg |-> busy_reg)
        else $error("serial clock outside busy");

    first_rise_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R13]
        ($rose(sclk_reg) && bits_reg == BIT_W'(RES_W - 1))
        |-> conversion_start_n_cnt_reg == CNT_W'(sac_pkg::FIRST_RISE_CYC))
        else $error("first clock rise mistimed");

    ext_stall_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
        (ext_reg && !sclk_rise && !load_pulse && busy_reg) |=> $stable(sh_reg))
        else $error("shift without host clock edge");

endmodule // sac_ctrl
`default_nettype wire

// ### pkg/sac_pkg.sv
// Constants, types and pin groups for the converter serial result port
//
// Summary of operation
// R1: A start falling edge begins hold and conversion; edges during conversion are ignored.
// R2: Starting a conversion does not depend on output enable.
// R3: Host starts conversions at most once every 25 us; no minimum rate.
// R4: Conversion plus acquisition fits in 25 us at most.
// R5: Busy goes low at start and stays low until the conversion completes.
// R6: Busy falls within 20 ns of start; stays low typically 12 us, 15 us max.
// R7: Busy rises about 90 ns after the internal conversion completes.
// R8: New result is copied into the output shift register just before busy rises.
// R9: Internal mode shifts the previous result out during conversion with own clock.
// R10: Each serial result is a 12-bit twos complement word, MSB first.
// R11: Internal mode holds each bit across both clock edges.
// R12: Internal mode keeps busy low over the whole serial frame.
// R13: Internal first clock rise about 2 us after start; period about 0.71 us.
// R14: Internal mode busy rises about 1.78 us after the last clock fall.
// R15: External mode shifts only on edges of the host serial clock.
// R16: Host should clock results out after the conversion completes.
// R17: Host keeps clock low or enable high 5 us before busy rises, else result lost.
// R18: Host clock starts 15 ns after start; phases 15 ns, period 35 ns minimum.
// R19: Host holds start high 15 ns before the next falling edge.
// R20: Host should keep start low until busy has risen.
// R21: Host may instead give a short low start pulse of about 100 ns.
// R22: Host keeps start static from 19 us after start until busy rises.
// R23: Codes are twos complement: 7FF, 000, FFF, 800.
// R24: Clock source select high means host clock; low means device clock.
// R25: Output enable high floats data, busy and device clock; low enables them.
// R26: Internal mode keeps data and clock low outside a serial frame.
// R27: External mode: host clock rise shifts next bit; host samples on falling edge.
// R28: Result taken from core input at completion; timing from a counter cleared at each start that holds while idle.
package sac_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS = 8;
    localparam int FIRST_RISE_NS = 2000;
    localparam int HALF_PERIOD_NS = 355;
    localparam int LAST_FALL_TO_BUSY_NS = 1780;
    localparam int DONE_TO_BUSY_NS = 90;
    localparam int GUARD_NS = 5000;
    localparam int BUSY_MAX_NS = 15000;
    localparam int CYCLE_MAX_NS = 25000;

    localparam int FIRST_RISE_CYC = FIRST_RISE_NS / CLK_NS;
    localparam int HALF_CYC = HALF_PERIOD_NS / CLK_NS;
    localparam int SETUP_CYC = HALF_CYC / 2;
    localparam int TAIL_CYC = LAST_FALL_TO_BUSY_NS / CLK_NS;
    localparam int FIN_CYC = DONE_TO_BUSY_NS / CLK_NS;
    localparam int GUARD_CYC = (GUARD_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
    localparam int CYCLE_MAX_CYC = CYCLE_MAX_NS / CLK_NS;

    // ************************************************************
    // Result word
    // ************************************************************
    localparam int RES_W = 12;
    localparam logic [11:0] CODE_POS_FS = 12'h7FF;
    localparam logic [11:0] CODE_MID = 12'h000;
    localparam logic [11:0] CODE_MID_M1 = 12'hFFF;
    localparam logic [11:0] CODE_NEG_FS = 12'h800;

    localparam int TX_START_I = FIRST_RISE_CYC - HALF_CYC;
    localparam int BUSY_RISE_I = FIRST_RISE_CYC + (RES_W - 1) * 2 * HALF_CYC + HALF_CYC + TAIL_CYC;
    localparam int DONE_I = BUSY_RISE_I - FIN_CYC;
    localparam int GUARD_START_I = BUSY_RISE_I - GUARD_CYC;

    localparam int CNT_W = 11;
    localparam int PH_W = 8;
    localparam logic [CNT_W-1:0] TX_START_M1 = CNT_W'(TX_START_I - 1);
    localparam logic [CNT_W-1:0] DONE_M1 = CNT_W'(DONE_I - 1);
    localparam logic [CNT_W-1:0] GUARD_START = CNT_W'(GUARD_START_I);
    localparam logic [PH_W-1:0] HALF_M1 = PH_W'(HALF_CYC - 1);
    localparam logic [PH_W-1:0] SETUP_PH = PH_W'(SETUP_CYC);
    localparam logic [PH_W-1:0] FIN_M1 = PH_W'(FIN_CYC - 1);

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam int CTRL_START_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOST_BIT = 1;
    localparam int ST_EXT_BIT = 2;
    localparam int ST_SKIP_BIT = 3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        SAC_IDLE = 3'h0,
        SAC_LEAD = 3'h1,
        SAC_SLOW = 3'h3,
        SAC_SHIGH = 3'h2,
        SAC_SEND = 3'h6,
        SAC_TAIL = 3'h7,
        SAC_FIN = 3'h5
    } sac_state_e;

    typedef struct packed {
        logic conversion_start_n;
        logic cs_n;
        logic clock_source_select;
        logic serial_bit_clock;
    } sac_pin_in_s;

    localparam logic [3:0] PIN_IN_RST = 4'hC;

    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic serial_bit_clock_o;
        logic serial_bit_clock_oe;
        logic busy_n_o;
        logic busy_n_oe;
    } sac_pin_out_s;

endpackage

// ### rtl/sac_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ************************************************************
    // One pair of flops per bit
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta_reg <= RST_VAL[gi];
                    sync_reg <= RST_VAL[gi];
                end
                else
                begin
                    meta_reg <= async_in[gi];
                    sync_reg <= meta_reg;
                end
            end
            assign sync_out[gi] = sync_reg;
        end
    endgenerate

endmodule // sac_sync
`default_nettype wire

// ### sim/sac_host_model.sv
// Host serial port model: drives the external data clock and gathers result bits
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
    input wire logic clk_sys,
    input wire logic ext_go,
    input wire logic stall_high,
    input wire logic bus_data,
    input wire logic bus_clk,
    output logic host_clk,
    output logic [11:0] word,
    output logic active
);
    // ************************************************************
    // Serial clock master and bit capture
    // ************************************************************
    int ph = 0;
    int half = 0;
    logic clk_d = 1'b0;
    initial host_clk = 1'b0;
    initial word = 12'h000;
    assign active = (half != 0);
    always @(posedge clk_sys)
    begin
        clk_d <= bus_clk;
        if (bus_clk && !clk_d)
            word <= {word[10:0], bus_data};
        if (stall_high)
            host_clk <= 1'b1;
        else if (ext_go && half == 0)
        begin
            half <= 24;
            ph <= 0;
        end
        else if (half != 0)
        begin
            ph <= ph + 1;
            // Six cycle phases give 48 ns high and low, 96 ns period
            if (ph == 5)
            begin
                ph <= 0;
                half <= half - 1;
                host_clk <= !host_clk;
                if (host_clk)
                    word <= {word[10:0], bus_data};
            end
        end
        else
            host_clk <= 1'b0; // Clock stands still outside frames
    end
endmodule // sac_host_model
`default_nettype wire

// ### sim/test_sar_adc_conversion_serial_port.sv
// Self-checking testbench for the converter serial result port
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_serial_port;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start_n = 1'b1;
    logic cs_n = 1'b1;
    logic ext_sel = 1'b0;
    logic ext_go = 1'b0;
    logic stall_high = 1'b0;
    logic host_clk;
    logic [11:0] word;
    logic active;
    logic [11:0] core_result = 12'h000;
    logic core_hold;
    logic data_w;
    logic clk_w;
    sac_pkg::sac_pin_in_s pin_in;
    sac_pkg::sac_pin_out_s pin_out;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    logic [11:0] prev;
    logic [31:0] q;
    logic e;
    logic [11:0] codes [6];
    always #4 clk_sys = ~clk_sys;
    assign pin_in = {start_n, cs_n, ext_sel, host_clk};
    // No pull on data: a released line shows the inverse so a stale bit cannot match
    assign data_w = pin_out.data_oe ? pin_out.data_o : !pin_out.data_o;
    assign clk_w = pin_out.serial_bit_clock_oe & pin_out.serial_bit_clock_o;
    sac_host_model host (.clk_sys(clk_sys), .ext_go(ext_go), .stall_high(stall_high),
        .bus_data(data_w), .bus_clk(clk_w), .host_clk(host_clk), .word(word), .active(active));
    sac_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pin_in), .pins_out(pin_out), .core_result(core_result),
        .core_hold(core_hold));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl, output int c);
        c = 0;
        while (pin_out.busy_n_o !== lvl)
        begin
            @(posedge clk_sys);
            c++;
            if (c > 4000)
            begin
                bad_count++;
                finish_test();
            end
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int c;
        c = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && c < 50)
        begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 50)
        begin
            bad_count++;
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic convert(input logic [11:0] code, input int mode);
        int t;
        core_result <= code;
        start_n <= 1'b0;
        wait_busy(1'b0, t);
        check(32'(t < 5), 32'h1);
        @(posedge clk_sys);
        check(32'(core_hold), 32'h1);
        if (mode != 0)
        begin
            repeat (mode) @(posedge clk_sys);
            start_n <= 1'b1;
            if (mode > 100)
            begin
                repeat (4) @(posedge clk_sys);
                start_n <= 1'b0;
            end
        end
        wait_busy(1'b1, t);
        t = t + 1 + mode + ((mode > 100) ? 4 : 0);
        check(32'(t >= 1480 && t <= 1488), 32'h1);
        start_n <= 1'b1;
        if (!ext_sel)
            check(32'({pin_out.data_o, pin_out.serial_bit_clock_o}), 32'h0);
        repeat (sac_pkg::CYCLE_MAX_CYC - 1480) @(posedge clk_sys);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        check(32'({pin_out.busy_n_o, pin_out.data_oe, pin_out.busy_n_oe}), 32'h4);
        void'($urandom(32'hA525));
        codes = '{12'h7FF, 12'h000, 12'hFFF, 12'h800, 12'($urandom), 12'($urandom)};
        cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 6; i++)
        begin
            convert(codes[i], (i == 2) ? 300 : ((i == 4) ? 10 : 0));
            if (i > 0)
                check(32'(word), 32'(prev));
            apb(1'b0, sac_pkg::OFF_RESULT, 32'h0);
            check(q & 32'hFFF, 32'(codes[i]));
            prev = codes[i];
        end
        $display("internal clock test done");
        cs_n <= 1'b1;
        convert(12'($urandom), 0);
        check(32'({pin_out.data_oe, pin_out.busy_n_oe}), 32'h0);
        cs_n <= 1'b0;
        ext_sel <= 1'b1;
        repeat (4) @(posedge clk_sys);
        prev = 12'($urandom);
        convert(prev, 0);
        check(32'(pin_out.serial_bit_clock_oe), 32'h0);
        ext_go <= 1'b1;
        @(posedge clk_sys);
        ext_go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (active && n < 400);
        if (n >= 400)
        begin
            bad_count++;
            finish_test();
        end
        check(32'(word), 32'(prev));
        $display("external clock test done");
        stall_high <= 1'b1;
        convert(12'($urandom), 0);
        stall_high <= 1'b0;
        apb(1'b0, sac_pkg::OFF_STATUS, 32'h0);
        check(q & 32'h6, 32'h6);
        apb(1'b1, sac_pkg::OFF_STATUS, 32'h2);
        apb(1'b0, sac_pkg::OFF_STATUS, 32'h0);
        check(q & 32'h6, 32'h4);
        apb(1'b0, 8'h0C, 32'h0);
        check({q[30:0], e}, 32'h1);
        apb(1'b1, sac_pkg::OFF_CTRL, 32'h1);
        wait_busy(1'b1, n);
        check(32'(n >= 1480 && n <= 1488), 32'h1);
        $display("status and register test done");
        finish_test();
    end
endmodule // test_sar_adc_conversion_serial_port
`default_nettype wire
